// ### verilog/rca_pkg.sv
/*
 * rca_pkg: constants, types and the count step function shared by the
 * upper calendar and alarm set-point register block.
 * assumes: an 8-bit data path and a 16-bit I/O address space.
 */
package rca_pkg;

    // ==========================================================
    // bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ==========================================================
    // register offsets in the I/O space
    localparam logic [15:0] MTH_COUNT_OFS = 16'h00E5;
    localparam logic [15:0] ANNUM_COUNT_OFS = 16'h00E6;
    localparam logic [15:0] EPOCH_COUNT_OFS = 16'h00E7;
    localparam logic [15:0] ALARM_S_OFS = 16'h00E8;
    localparam logic [15:0] ALARM_M_OFS = 16'h00E9;

    // ==========================================================
    // count limits, decimal and binary coding
    localparam logic [7:0] MTH_FIRST = 8'h01;
    localparam logic [7:0] MTH_LAST_BCD = 8'h12;
    localparam logic [7:0] MTH_LAST_BIN = 8'h0C;
    localparam logic [7:0] ANNUM_FIRST = 8'h00;
    localparam logic [7:0] ANNUM_LAST_BCD = 8'h99;
    localparam logic [7:0] ANNUM_LAST_BIN = 8'h63;
    localparam logic [7:0] EPOCH_FIRST = 8'h00;
    localparam logic [7:0] EPOCH_LAST_BCD = 8'h99;
    localparam logic [7:0] EPOCH_LAST_BIN = 8'h63;

    // ==========================================================
    // digit and misc constants
    localparam logic [3:0] DIGIT_LAST = 4'h9;
    localparam logic [3:0] DIGIT_ZERO = 4'h0;
    localparam logic [3:0] NIB_ONE = 4'h1;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] RD_IDLE = 8'h00;
    localparam int ALM_SEC_BIT = 0;
    localparam int ALM_MIN_BIT = 1;

    // ==========================================================
    // step result: next value and a wrap flag that carries upward
    typedef struct packed {
        logic wrap;
        logic [7:0] val;
    } rca_step_s;

    // one count step in either coding; wraps from last back to first
    function automatic rca_step_s rcaStep(
        input logic [7:0] cur,
        input logic bcd,
        input logic [7:0] lastBcd,
        input logic [7:0] lastBin,
        input logic [7:0] first
    );
        rca_step_s res;
        logic [7:0] last;
        last = bcd ? lastBcd : lastBin;
        res.wrap = 1'b0;
        if (cur == last) begin
            res.wrap = 1'b1;
            res.val = first;
        end else if (bcd && (cur[3:0] >= DIGIT_LAST)) begin
            res.val = {cur[7:4] + NIB_ONE, DIGIT_ZERO};
        end else if (bcd) begin
            res.val = {cur[7:4], cur[3:0] + NIB_ONE};
        end else begin
            res.val = cur + BYTE_ONE;
        end
        return res;
    endfunction

endpackage

// ### verilog/rca_alarm_if.sv
/*
 * rca_alarm_if: carries alarm set points, live counts and enables from
 * the register block to the comparator, and the match back.
 * assumes: both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
interface rca_alarm_if;
    logic [7:0] setSec;
    logic [7:0] setMin;
    logic [7:0] curSec;
    logic [7:0] curMin;
    logic [1:0] matchOn;
    logic match;

    // ==========================================================
    // comparator end
    modport cmp (
        input setSec,
        input setMin,
        input curSec,
        input curMin,
        input matchOn,
        output match
    );

    // ==========================================================
    // register block end
    modport owner (
        output setSec,
        output setMin,
        output curSec,
        output curMin,
        output matchOn,
        input match
    );
endinterface

// ### verilog/rca_alarm_cmp.sv
/*
 * rca_alarm_cmp: combinational seconds and minutes alarm comparator.
 * assumes: the caller samples match only at a count increment or when
 * the count lock closes; values are compared as raw bytes, which is
 * exact in both codings since both sides use the same coding.
 */
`timescale 1ns/1ps
module rca_alarm_cmp
    import rca_pkg::*;
(
    // alarm link
    rca_alarm_if.cmp alm
);

    // ==========================================================
    // compare
    logic secOk;
    logic minOk;

    // a disabled field always agrees; with none enabled there is no alarm
    assign secOk = !alm.matchOn[ALM_SEC_BIT] || (alm.setSec == alm.curSec);
    assign minOk = !alm.matchOn[ALM_MIN_BIT] || (alm.setMin == alm.curMin);
    assign alm.match = (|alm.matchOn) && secOk && minOk;

endmodule

// ### verilog/rca_calendar_alarm_regs.sv
/*
 * rca_calendar_alarm_regs: month, year and century count registers with
 * their carry chain, and the seconds and minutes alarm set points, on
 * the CPU I/O address and data bus.
 * assumes: strobes and address are synchronous to ref_clk; the lock,
 * coding select and alarm enables come from the control registers
 * held elsewhere; day-of-month carry and the seconds tick come from the
 * lower counters of the same clock.
 */
// Summary of operation
// - decimal month: tens digit 0-1 in upper nibble, ones 0-9 lower.
// - binary month: one byte from 01h to 0Ch.
// - decimal year: tens 0-9 in bits 7-4, ones 0-9 in bits 3-0.
// - binary year: one byte from 00h to 63h.
// - decimal century: two digits 0-9, tens high nibble, ones low.
// - binary century: one byte from 00h to 63h.
// - decimal alarm seconds: tens 0-5 upper nibble, ones 0-9 lower.
// - binary alarm seconds: one byte from 00h to 3Bh.
// - decimal alarm minutes: tens 0-5 upper nibble, ones 0-9 lower.
// - binary alarm minutes: one byte from 00h to 3Bh.
// - reset leaves month, year and century counts untouched.
// - count writes ignored while locked; accepted while write-open.
// - alarm set points always read/write and survive reset.
// - coding select chooses BCD or binary counting; the alarm compare is raw bytes in either coding.
// - write-open halts counting; locked resumes; reset means locked.
// - seconds alarm needs enable bit 0, minutes alarm bit 1.
`timescale 1ns/1ps
module rca_calendar_alarm_regs
    import rca_pkg::*;
#(
    parameter int P_ADDR_W = ADDR_W,
    parameter int P_DATA_W = DATA_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // CPU I/O bus
    input wire logic [P_ADDR_W-1:0] ioAddr,
    input wire logic ioWrEn,
    input wire logic ioRdEn,
    input wire logic [P_DATA_W-1:0] ioWrData,
    output logic [P_DATA_W-1:0] ioRdData,
    output logic ioRdValid,
    // control bits from the control registers
    input wire logic countWriteOpen,
    input wire logic decimalCodingSel,
    input wire logic alarm_s_match_on,
    input wire logic alarm_m_match_on,
    // lower counter links
    input wire logic monthCarryIn,
    input wire logic secTick,
    input wire logic [7:0] curSecCount,
    input wire logic [7:0] curMinCount,
    // results
    output logic [7:0] mthCount,
    output logic [7:0] annumCount,
    output logic [7:0] epochCount,
    output logic epochWrap,
    output logic alarmHit
);

    // ==========================================================
    // elaboration checks: the field layouts are byte wide
    if (P_DATA_W != DATA_W) begin : gBadData
        $error("rca_calendar_alarm_regs: data width must be 8");
    end
    if (P_ADDR_W != ADDR_W) begin : gBadAddr
        $error("rca_calendar_alarm_regs: address width must be 16");
    end

    // ==========================================================
    // state types
    // time-keeping contents carry no reset: they must outlive a device reset
    typedef struct packed {
        logic [7:0] mth;
        logic [7:0] annum;
        logic [7:0] epoch;
        logic [7:0] alarmS;
        logic [7:0] alarmM;
    } rca_dat_s;

    // bus answer and event state, defined from reset
    typedef struct packed {
        logic lockPrev;
        logic rdValid;
        logic [7:0] rdData;
        logic hit;
        logic wrap;
    } rca_ctl_s;

    rca_dat_s dat_r;
    rca_dat_s dat_nxt;
    rca_ctl_s ctl_r;
    rca_ctl_s ctl_nxt;

    // ==========================================================
    // decode and step helpers
    logic countRun;
    logic wrOpen;
    logic evalNow;
    rca_step_s mthStep;
    rca_step_s annumStep;
    rca_step_s epochStep;

    // address match against one register offset
    function automatic logic addrIs(input logic [15:0] a, input logic [15:0] ofs);
        return a == ofs;
    endfunction

    // the lock gates both the count chain and the count writes
    assign countRun = !countWriteOpen;
    assign wrOpen = ioWrEn && countWriteOpen;

    // step chain, each stage in the coding that is selected now
    assign mthStep = rcaStep(dat_r.mth, decimalCodingSel, MTH_LAST_BCD, MTH_LAST_BIN, MTH_FIRST);
    assign annumStep = rcaStep(dat_r.annum, decimalCodingSel, ANNUM_LAST_BCD, ANNUM_LAST_BIN,
        ANNUM_FIRST);
    assign epochStep = rcaStep(dat_r.epoch, decimalCodingSel, EPOCH_LAST_BCD, EPOCH_LAST_BIN,
        EPOCH_FIRST);

    // ==========================================================
    // alarm comparator
    rca_alarm_if alm ();

    assign alm.setSec = dat_r.alarmS;
    assign alm.setMin = dat_r.alarmM;
    assign alm.curSec = curSecCount;
    assign alm.curMin = curMinCount;
    assign alm.matchOn = {alarm_m_match_on, alarm_s_match_on};

    rca_alarm_cmp rca_alarm_cmp_i (
        .alm(alm.cmp)
    );

    // compare after a running seconds increment, or as the lock closes
    assign evalNow = (countRun && secTick) || (ctl_r.lockPrev && !countWriteOpen);

    // ==========================================================
    // next state
    always_comb begin
        dat_nxt = dat_r;
        ctl_nxt = ctl_r;

        // count chain: a month carry only moves upward while locked
        if (countRun && monthCarryIn) begin
            dat_nxt.mth = mthStep.val;
            if (mthStep.wrap) begin
                dat_nxt.annum = annumStep.val;
                if (annumStep.wrap) begin
                    dat_nxt.epoch = epochStep.val;
                end
            end
        end
        ctl_nxt.wrap = countRun && monthCarryIn && mthStep.wrap && annumStep.wrap && epochStep.wrap;

        // count writes land only while write-open; counting is halted then
        if (wrOpen && addrIs(ioAddr, MTH_COUNT_OFS)) begin
            dat_nxt.mth = ioWrData;
        end
        if (wrOpen && addrIs(ioAddr, ANNUM_COUNT_OFS)) begin
            dat_nxt.annum = ioWrData;
        end
        if (wrOpen && addrIs(ioAddr, EPOCH_COUNT_OFS)) begin
            dat_nxt.epoch = ioWrData;
        end

        // set points take writes whatever the lock says
        if (ioWrEn && addrIs(ioAddr, ALARM_S_OFS)) begin
            dat_nxt.alarmS = ioWrData;
        end
        if (ioWrEn && addrIs(ioAddr, ALARM_M_OFS)) begin
            dat_nxt.alarmM = ioWrData;
        end

        // alarm event and lock history
        ctl_nxt.lockPrev = countWriteOpen;
        ctl_nxt.hit = evalNow && alm.match;

        // read answer: registered, one cycle after the strobe
        ctl_nxt.rdValid = ioRdEn;
        ctl_nxt.rdData = RD_IDLE;
        if (ioRdEn) begin
            case (ioAddr)
                MTH_COUNT_OFS: begin
                    ctl_nxt.rdData = dat_r.mth;
                end
                ANNUM_COUNT_OFS: begin
                    ctl_nxt.rdData = dat_r.annum;
                end
                EPOCH_COUNT_OFS: begin
                    ctl_nxt.rdData = dat_r.epoch;
                end
                ALARM_S_OFS: begin
                    ctl_nxt.rdData = dat_r.alarmS;
                end
                ALARM_M_OFS: begin
                    ctl_nxt.rdData = dat_r.alarmM;
                end
                default: begin
                    ctl_nxt.rdData = RD_IDLE; // other offsets belong to other blocks
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    // no reset on the contents: a device reset must not disturb the calendar
    always_ff @(posedge ref_clk) begin
        dat_r <= dat_nxt;
    end

    // lock history resets as closed, so release from reset raises no event
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r <= '0;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign ioRdData = ctl_r.rdData;
    assign ioRdValid = ctl_r.rdValid;
    assign mthCount = dat_r.mth;
    assign annumCount = dat_r.annum;
    assign epochCount = dat_r.epoch;
    assign epochWrap = ctl_r.wrap;
    assign alarmHit = ctl_r.hit;

endmodule

// ### bench/rca_cpu_model.sv
/*
 * rca_cpu_model: CPU side of the I/O bus, single byte reads and writes.
 * assumes: bus inputs of the block are sampled at the rising edge.
 */
`timescale 1ns/1ps
module rca_cpu_model
    import rca_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // request
    output logic [ADDR_W-1:0] ioAddr,
    output logic ioWrEn,
    output logic ioRdEn,
    output logic [7:0] ioWrData,
    // answer
    input wire logic [7:0] ioRdData,
    input wire logic ioRdValid
);
    // ==========================================================
    // bus cycles: change at falling edge, hold across one rising edge
    initial begin
        {ioAddr, ioWrEn, ioRdEn, ioWrData} = '0;
    end
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {ioAddr, ioWrData, ioWrEn} = {a, d, 1'b1};
        @(negedge ref_clk);
        ioWrEn = 1'b0;
        ioWrData = ~d; // released data must not look valid
    endtask
    task rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(negedge ref_clk);
        {ioAddr, ioRdEn} = {a, 1'b1};
        @(negedge ref_clk);
        ioRdEn = 1'b0;
        {d, v} = {ioRdData, ioRdValid}; // answer stands one cycle only
    endtask
endmodule

// ### bench/rca_calendar_alarm_regs_assertions.sv
/*
 * rca_regs_chk: port-level checks of the calendar and alarm registers.
 * assumes: bound to rca_calendar_alarm_regs, one clock domain.
 */
`timescale 1ns/1ps
module rca_regs_chk
    import rca_pkg::*;
#(
    parameter int P_ADDR_W = ADDR_W,
    parameter int P_DATA_W = DATA_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // bus
    input wire logic [P_ADDR_W-1:0] ioAddr,
    input wire logic ioWrEn,
    input wire logic ioRdEn,
    input wire logic [P_DATA_W-1:0] ioWrData,
    input wire logic [P_DATA_W-1:0] ioRdData,
    input wire logic ioRdValid,
    // control and events
    input wire logic countWriteOpen,
    input wire logic decimalCodingSel,
    input wire logic alarm_s_match_on,
    input wire logic alarm_m_match_on,
    input wire logic monthCarryIn,
    input wire logic secTick,
    // results
    input wire logic [7:0] mthCount,
    input wire logic [7:0] annumCount,
    input wire logic [7:0] epochCount,
    input wire logic epochWrap,
    input wire logic alarmHit
);
    // ==========================================================
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_RD_ANSWER: assert property (ioRdEn |=> ioRdValid) else $error("read not answered");
    AST_RD_IDLE: assert property (!ioRdEn |=> !ioRdValid && ioRdData == RD_IDLE) else $error("idle read bus");
    AST_RD_MONTH: assert property (ioRdEn && ioAddr == MTH_COUNT_OFS |=> ioRdData == $past(mthCount))
        else $error("month read");
    AST_LOCK_WR: assert property (ioWrEn && !countWriteOpen && ioAddr == MTH_COUNT_OFS && !monthCarryIn
        |=> $stable(mthCount)) else $error("locked write taken");
    AST_OPEN_WR: assert property (ioWrEn && countWriteOpen && ioAddr == ANNUM_COUNT_OFS
        |=> annumCount == $past(ioWrData)) else $error("open write lost");
    AST_HALT: assert property (countWriteOpen && !ioWrEn |=> $stable({mthCount, annumCount, epochCount}))
        else $error("count moved while open");
    AST_MTH_WRAP: assert property (!countWriteOpen && monthCarryIn
        && mthCount == (decimalCodingSel ? MTH_LAST_BCD : MTH_LAST_BIN)
        |=> mthCount == MTH_FIRST && annumCount != $past(annumCount)) else $error("month wrap");
    AST_EPOCH_WRAP: assert property (epochWrap |-> epochCount == EPOCH_FIRST && $past(monthCarryIn))
        else $error("century wrap");
    AST_NO_ENABLE: assert property (!alarm_s_match_on && !alarm_m_match_on |=> !alarmHit)
        else $error("alarm without enable");
    AST_HIT_CAUSE: assert property (alarmHit |-> $past(secTick) || $past(countWriteOpen, 2))
        else $error("alarm without cause");
    // main scenarios reached
    cover property (epochWrap);
    cover property (alarmHit);
    cover property (ioWrEn && !countWriteOpen && ioAddr == MTH_COUNT_OFS);
endmodule

bind rca_calendar_alarm_regs rca_regs_chk #(.P_ADDR_W(P_ADDR_W), .P_DATA_W(P_DATA_W)) chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid), .countWriteOpen(countWriteOpen),
    .decimalCodingSel(decimalCodingSel), .alarm_s_match_on(alarm_s_match_on),
    .alarm_m_match_on(alarm_m_match_on), .monthCarryIn(monthCarryIn), .secTick(secTick),
    .mthCount(mthCount), .annumCount(annumCount), .epochCount(epochCount), .epochWrap(epochWrap),
    .alarmHit(alarmHit));

// ### bench/test_rca_calendar_alarm_regs.sv
/*
 * test_rca_calendar_alarm_regs: directed tests through the CPU model.
 * assumes: the checker is bound; inputs change at the falling edge.
 */
`timescale 1ns/1ps
module test_rca_calendar_alarm_regs
    import rca_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] ioAddr;
    logic ioWrEn, ioRdEn, ioRdValid, epochWrap, alarmHit, h, w;
    logic [7:0] ioWrData, ioRdData, mthCount, annumCount, epochCount;
    logic countWriteOpen = 0, decimalCodingSel = 0, alarm_s_match_on = 0, alarm_m_match_on = 0;
    logic monthCarryIn = 0, secTick = 0;
    logic [7:0] curSecCount = 8'h00, curMinCount = 8'h45;
    int errorCnt = 0, checks = 0, cycles = 0;
    logic [7:0] mLast [2] = '{MTH_LAST_BIN, MTH_LAST_BCD};
    logic [7:0] yLast [2] = '{ANNUM_LAST_BIN, ANNUM_LAST_BCD};
    logic [7:0] after9 [2] = '{8'h0A, 8'h10};

    // ==========================================================
    // clock, design and far side
    always #5 ref_clk = ~ref_clk;
    rca_calendar_alarm_regs rca_calendar_alarm_regs_i (.ref_clk(ref_clk), .rst_n(rst_n), .ioAddr(ioAddr),
        .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
        .countWriteOpen(countWriteOpen), .decimalCodingSel(decimalCodingSel),
        .alarm_s_match_on(alarm_s_match_on), .alarm_m_match_on(alarm_m_match_on),
        .monthCarryIn(monthCarryIn), .secTick(secTick), .curSecCount(curSecCount),
        .curMinCount(curMinCount), .mthCount(mthCount), .annumCount(annumCount),
        .epochCount(epochCount), .epochWrap(epochWrap), .alarmHit(alarmHit));
    rca_cpu_model rca_cpu_model_i (.ref_clk(ref_clk), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
        .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid));

    // ==========================================================
    // compare, read and event tasks
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task rdChk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        rca_cpu_model_i.rd(a, d, v);
        chk("ioRdValid", 8'h01, {7'h00, v});
        chk("ioRdData", exp, d);
    endtask
    // one event pulse; results are registered, so look one cycle on
    task step(input logic carry, input logic tick);
        @(negedge ref_clk);
        {monthCarryIn, secTick} = {carry, tick};
        @(negedge ref_clk);
        {monthCarryIn, secTick} = 2'b00;
        {h, w} = {alarmHit, epochWrap};
    endtask
    task alm(input logic [1:0] en, input logic [7:0] sec, input logic exp);
        {alarm_m_match_on, alarm_s_match_on} = en;
        curSecCount = sec;
        step(1'b0, 1'b1);
        chk("alarmHit", {7'h00, exp}, {7'h00, h});
    endtask
    task results();
        $display("checks %0d mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard: whole run needs well under 1000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            results();
        end
    end

    // ==========================================================
    // tests
    initial begin
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        for (int m = 0; m < 2; m++) begin
            decimalCodingSel = m[0];
            countWriteOpen = 1'b1;
            rca_cpu_model_i.wr(MTH_COUNT_OFS, mLast[m]);
            rca_cpu_model_i.wr(ANNUM_COUNT_OFS, yLast[m]);
            rca_cpu_model_i.wr(EPOCH_COUNT_OFS, yLast[m]);
            rdChk(ANNUM_COUNT_OFS, yLast[m]);
            step(1'b1, 1'b0);
            chk("mthCount open", mLast[m], mthCount);
            countWriteOpen = 1'b0;
            step(1'b1, 1'b0);
            chk("epochWrap", 8'h01, {7'h00, w});
            chk("mthCount", MTH_FIRST, mthCount);
            chk("annumCount", ANNUM_FIRST, annumCount);
            chk("epochCount", EPOCH_FIRST, epochCount);
            rca_cpu_model_i.wr(MTH_COUNT_OFS, 8'h09);
            rdChk(MTH_COUNT_OFS, MTH_FIRST);
            rca_cpu_model_i.wr(EPOCH_COUNT_OFS, 8'h09);
            rdChk(EPOCH_COUNT_OFS, EPOCH_FIRST);
            countWriteOpen = 1'b1;
            rca_cpu_model_i.wr(MTH_COUNT_OFS, 8'h09);
            countWriteOpen = 1'b0;
            step(1'b1, 1'b0);
            chk("mthCount step", after9[m], mthCount);
        end
        $display("test count_chain done");
        rca_cpu_model_i.wr(ALARM_S_OFS, 8'h59);
        rca_cpu_model_i.wr(ALARM_M_OFS, 8'h45);
        rdChk(ALARM_S_OFS, 8'h59);
        rdChk(ALARM_M_OFS, 8'h45);
        alm(2'b01, 8'h59, 1'b1);
        alm(2'b01, 8'h58, 1'b0);
        alm(2'b11, 8'h59, 1'b1);
        curMinCount = 8'h44;
        alm(2'b11, 8'h59, 1'b0);
        alm(2'b00, 8'h59, 1'b0);
        countWriteOpen = 1'b1;
        alm(2'b01, 8'h59, 1'b0);
        countWriteOpen = 1'b0;
        @(negedge ref_clk);
        chk("alarmHit close", 8'h01, {7'h00, alarmHit});
        $display("test alarm done");
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        chk("mthCount reset", 8'h10, mthCount);
        rdChk(ALARM_S_OFS, 8'h59);
        rdChk(16'h00E0, RD_IDLE);
        $display("test reset done");
        // binary coding: set points take plain byte values up to 3Bh
        decimalCodingSel = 1'b0;
        rca_cpu_model_i.wr(ALARM_S_OFS, 8'h3B);
        rca_cpu_model_i.wr(ALARM_M_OFS, 8'h3B);
        rdChk(ALARM_S_OFS, 8'h3B);
        rdChk(ALARM_M_OFS, 8'h3B);
        curMinCount = 8'h3B;
        alm(2'b11, 8'h3B, 1'b1);
        alm(2'b11, 8'h3A, 1'b0);
        $display("test binary alarm done");
        results();
    end
endmodule
